/* hw/adc_alert_cfg.svh */
// Functional notes
// (RL1) Style bit 0 selects traditional comparison, 1 selects window comparison.
// (RL2) Polarity bit 0 drives the alert pin active low, 1 active high.
// (RL3) Without latching, the alert releases itself once results return inside limits (window) or fall below the lower limit (traditional).
// (RL4) With latching, the alert holds until conversion data is read or alert response.
// (RL5) On alert response each alerting device sends its address; lowest address wins.
// (RL6) Successive faults needed before alert: code 00 one, 01 two, 10 four.
// (RL7) Fault count code 11 (reset) disables comparator and floats the alert pin.
// (RL8) Lower and upper limits are separate 16-bit two's complement registers.
// (RL9) Host rewrites both limits whenever the gain stage setting changes.
// (RL10) Upper limit MSB 1 with lower limit MSB 0 selects conversion-ready signalling.
// (RL11) Host keeps the upper limit greater than the lower limit.
// (RL12) Ready signalling in single-shot shows the conversion-idle flag on the pin.
// (RL13) Ready signalling in continuous mode pulses the pin at each conversion end.
// (RL14) Pointer 10 selects the lower limit, pointer 11 the upper limit.
// (RL15) Conversion-idle flag reads 0 during a conversion and 1 otherwise.
// (RL16) Limits compare against the last result, zero from reset to first conversion.
// (RL17) Traditional: fault above upper, release below lower; window: fault outside limits.
// (RL18) The successive-fault counter clears on any result that is not a fault.
`ifndef ADC_ALERT_CFG_SVH
`define ADC_ALERT_CFG_SVH

// Register pointer codes
`define PTR_CONV 2'h0
`define PTR_CONFIG 2'h1
`define PTR_LOWER 2'h2
`define PTR_UPPER 2'h3

// Reset values
`define CONFIG_RESET 16'h8583
`define LOWER_RESET 16'h8000
`define UPPER_RESET 16'h7FFF
`define CONV_RESET 16'h0000

// Fault count field codes and the counts they need
`define QUE_ONE 2'h0
`define QUE_TWO 2'h1
`define QUE_FOUR 2'h2
`define QUE_OFF 2'h3
`define NEED_ONE 3'h1
`define NEED_TWO 3'h2
`define NEED_FOUR 3'h4

// Link constants
`define ALERT_RESPONSE_ADDR 7'h0C
`define BYTE_BITS 4'h8
`define MODE_SINGLE 1'h1

// Ready pulse timing
`define CLK_PERIOD_NS 10
`define READY_PULSE_NS 8000
`define READY_PULSE_CYCLES ((`READY_PULSE_NS) / (`CLK_PERIOD_NS))
`define READY_CNT_W 10

`endif

/* hw/adc_alert_pkg.sv */
package adc_alert_pkg;

    // Configuration register layout
    typedef struct packed {
        logic conversionIdleFlag;
        logic [2:0] inputSelect;
        logic [2:0] gainStageSetting;
        logic singleShot;
        logic [2:0] dataRate;
        logic windowStyle;
        logic alertPinPolarity;
        logic alertLatchEnable;
        logic [1:0] faultCountAndDisable;
    } cfg_t;

    // Serial link states
    typedef enum logic [2:0] {
        LINK_IDLE,
        LINK_ADDR,
        LINK_ADDR_ACK,
        LINK_WRITE,
        LINK_WRITE_ACK,
        LINK_READ,
        LINK_READ_ACK
    } link_state_t;

endpackage : adc_alert_pkg

/* hw/adc_threshold_alert_logic.sv */
`timescale 1ns/10ps
`include "adc_alert_cfg.svh"

module adc_threshold_alert_logic #(
    parameter int READY_PULSE = `READY_PULSE_CYCLES
) (
    input wire logic clk, // System clock
    input wire logic sys_rst, // Synchronous reset, active high
    input wire logic sclIn, // Serial clock pin
    input wire logic sdaIn, // Serial data pin level
    output logic sdaOut, // Serial data drive value
    output logic sdaOe, // Serial data drive enable
    input wire logic [6:0] devAddr, // Bus address strap
    input wire logic convDone, // Conversion complete pulse
    input wire logic [15:0] convResult, // Result valid with convDone
    input wire logic convBusy, // Conversion in progress
    output adc_alert_pkg::cfg_t configOut, // Configuration to converter
    output logic startSingle, // Single-shot start pulse
    output logic alertOut, // Alert pin drive value
    output logic alertOe // Alert pin drive enable
);

    // Pin synchronisers and filtered levels
    logic [2:0] sclSync_reg, sdaSync_reg;
    logic sclFilt_reg, sdaFilt_reg, sclPrev_reg, sdaPrev_reg;
    logic sclFilt_next, sdaFilt_next;

    always_comb begin
        sclFilt_next = (sclSync_reg[2] == sclSync_reg[1]) ? sclSync_reg[2] : sclFilt_reg;
        sdaFilt_next = (sdaSync_reg[2] == sdaSync_reg[1]) ? sdaSync_reg[2] : sdaFilt_reg;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sclSync_reg <= 3'h7;
            sdaSync_reg <= 3'h7;
            sclFilt_reg <= 1'b1;
            sdaFilt_reg <= 1'b1;
            sclPrev_reg <= 1'b1;
            sdaPrev_reg <= 1'b1;
        end else begin
            sclSync_reg <= {sclSync_reg[1:0], sclIn};
            sdaSync_reg <= {sdaSync_reg[1:0], sdaIn};
            sclFilt_reg <= sclFilt_next;
            sdaFilt_reg <= sdaFilt_next;
            sclPrev_reg <= sclFilt_reg;
            sdaPrev_reg <= sdaFilt_reg;
        end
    end

    // Link events
    logic sclRise, sclFall, startSeen, stopSeen;
    assign sclRise = sclFilt_reg & ~sclPrev_reg;
    assign sclFall = ~sclFilt_reg & sclPrev_reg;
    assign startSeen = sclFilt_reg & sclPrev_reg & sdaPrev_reg & ~sdaFilt_reg;
    assign stopSeen = sclFilt_reg & sclPrev_reg & ~sdaPrev_reg & sdaFilt_reg;

    // Link and register state
    adc_alert_pkg::link_state_t state_reg, state_next;
    adc_alert_pkg::cfg_t cfg_reg, cfg_next;
    logic [15:0] lower_reg, lower_next, upper_reg, upper_next, conv_reg, conv_next;
    logic [7:0] shift_reg, shift_next, tx_reg, tx_next, msb_reg, msb_next;
    logic [3:0] bitCnt_reg, bitCnt_next;
    logic [1:0] ptr_reg, ptr_next, byteIdx_reg, byteIdx_next;
    logic [6:0] addr_reg;
    logic rw_reg, rw_next, ara_reg, ara_next, rdLow_reg, rdLow_next;
    logic ackSeen_reg, ackSeen_next, sdaOe_reg, sdaOe_next, start_next, linkClear;
    logic alertReg, rdyMode, araHit;
    logic [15:0] readWord;

    assign rdyMode = upper_reg[15] & ~lower_reg[15]; // RL10
    assign araHit = (shift_reg[7:1] == `ALERT_RESPONSE_ADDR) && shift_reg[0] && alertReg
        && (cfg_reg.faultCountAndDisable != `QUE_OFF); // RL5

    // Read data by pointer, idle flag in the top config bit
    always_comb begin
        unique case (ptr_reg)
            `PTR_CONV: readWord = conv_reg;
            `PTR_CONFIG: readWord = {~convBusy, cfg_reg[14:0]}; // RL15
            `PTR_LOWER: readWord = lower_reg; // RL14
            `PTR_UPPER: readWord = upper_reg; // RL14
        endcase
    end

    // Link state machine next values
    always_comb begin
        state_next = state_reg;
        cfg_next = cfg_reg;
        lower_next = lower_reg;
        upper_next = upper_reg;
        shift_next = shift_reg;
        tx_next = tx_reg;
        msb_next = msb_reg;
        bitCnt_next = bitCnt_reg;
        ptr_next = ptr_reg;
        byteIdx_next = byteIdx_reg;
        rw_next = rw_reg;
        ara_next = ara_reg;
        rdLow_next = rdLow_reg;
        ackSeen_next = ackSeen_reg;
        sdaOe_next = sdaOe_reg;
        start_next = 1'b0;
        linkClear = 1'b0;
        if (stopSeen) begin
            state_next = adc_alert_pkg::LINK_IDLE;
            sdaOe_next = 1'b0;
        end else if (startSeen) begin
            state_next = adc_alert_pkg::LINK_ADDR;
            bitCnt_next = 4'h0;
            sdaOe_next = 1'b0;
        end else begin
            unique case (state_reg)
                adc_alert_pkg::LINK_IDLE: begin
                end
                adc_alert_pkg::LINK_ADDR: begin
                    if (sclRise) begin
                        shift_next = {shift_reg[6:0], sdaFilt_reg};
                        bitCnt_next = bitCnt_reg + 4'h1;
                    end else if (sclFall && bitCnt_reg == `BYTE_BITS) begin
                        bitCnt_next = 4'h0;
                        rw_next = shift_reg[0];
                        ara_next = araHit;
                        if (shift_reg[7:1] == addr_reg || araHit) begin
                            state_next = adc_alert_pkg::LINK_ADDR_ACK;
                            sdaOe_next = 1'b1;
                        end else begin
                            state_next = adc_alert_pkg::LINK_IDLE;
                        end
                    end
                end
                adc_alert_pkg::LINK_ADDR_ACK: begin
                    if (sclFall) begin
                        byteIdx_next = 2'h0;
                        if (rw_reg) begin
                            state_next = adc_alert_pkg::LINK_READ;
                            tx_next = ara_reg ? {addr_reg, 1'b0} : readWord[15:8]; // RL5
                            sdaOe_next = ~tx_next[7];
                            rdLow_next = 1'b1;
                            linkClear = ~ara_reg && (ptr_reg == `PTR_CONV); // RL4
                        end else begin
                            state_next = adc_alert_pkg::LINK_WRITE;
                            sdaOe_next = 1'b0;
                        end
                    end
                end
                adc_alert_pkg::LINK_WRITE: begin
                    if (sclRise) begin
                        shift_next = {shift_reg[6:0], sdaFilt_reg};
                        bitCnt_next = bitCnt_reg + 4'h1;
                    end else if (sclFall && bitCnt_reg == `BYTE_BITS) begin
                        bitCnt_next = 4'h0;
                        state_next = adc_alert_pkg::LINK_WRITE_ACK;
                        sdaOe_next = 1'b1;
                        if (byteIdx_reg == 2'h0) begin
                            ptr_next = shift_reg[1:0]; // RL14
                            byteIdx_next = 2'h1;
                        end else if (byteIdx_reg == 2'h1) begin
                            msb_next = shift_reg;
                            byteIdx_next = 2'h2;
                        end else begin
                            byteIdx_next = 2'h1;
                            unique case (ptr_reg)
                                `PTR_CONV: begin
                                end
                                `PTR_CONFIG: begin
                                    cfg_next = {msb_reg, shift_reg};
                                    start_next = msb_reg[7] & ~convBusy & cfg_next.singleShot;
                                end
                                `PTR_LOWER: lower_next = {msb_reg, shift_reg}; // RL8
                                `PTR_UPPER: upper_next = {msb_reg, shift_reg}; // RL8
                            endcase
                        end
                    end
                end
                adc_alert_pkg::LINK_WRITE_ACK: begin
                    if (sclFall) begin
                        state_next = adc_alert_pkg::LINK_WRITE;
                        sdaOe_next = 1'b0;
                    end
                end
                adc_alert_pkg::LINK_READ: begin
                    if (sclRise) begin
                        bitCnt_next = bitCnt_reg + 4'h1;
                        if (ara_reg && !sdaOe_reg && !sdaFilt_reg) begin
                            state_next = adc_alert_pkg::LINK_IDLE; // RL5
                        end
                    end else if (sclFall) begin
                        if (bitCnt_reg == `BYTE_BITS) begin
                            bitCnt_next = 4'h0;
                            sdaOe_next = 1'b0;
                            state_next = adc_alert_pkg::LINK_READ_ACK;
                            linkClear = ara_reg; // RL4
                        end else begin
                            tx_next = {tx_reg[6:0], 1'b0};
                            sdaOe_next = ~tx_next[7];
                        end
                    end
                end
                adc_alert_pkg::LINK_READ_ACK: begin
                    if (sclRise) begin
                        ackSeen_next = ~sdaFilt_reg;
                    end else if (sclFall) begin
                        if (ackSeen_reg && !ara_reg) begin
                            tx_next = rdLow_reg ? readWord[7:0] : readWord[15:8];
                            rdLow_next = ~rdLow_reg;
                            sdaOe_next = ~tx_next[7];
                            state_next = adc_alert_pkg::LINK_READ;
                        end else begin
                            state_next = adc_alert_pkg::LINK_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_reg <= adc_alert_pkg::LINK_IDLE;
            cfg_reg <= `CONFIG_RESET;
            lower_reg <= `LOWER_RESET;
            upper_reg <= `UPPER_RESET;
            shift_reg <= 8'h00;
            tx_reg <= 8'h00;
            msb_reg <= 8'h00;
            bitCnt_reg <= 4'h0;
            ptr_reg <= `PTR_CONV;
            byteIdx_reg <= 2'h0;
            rw_reg <= 1'b0;
            ara_reg <= 1'b0;
            rdLow_reg <= 1'b0;
            ackSeen_reg <= 1'b0;
            sdaOe_reg <= 1'b0;
            startSingle <= 1'b0;
            addr_reg <= devAddr; // Strap captured while reset is held
        end else begin
            state_reg <= state_next;
            cfg_reg <= cfg_next;
            lower_reg <= lower_next;
            upper_reg <= upper_next;
            shift_reg <= shift_next;
            tx_reg <= tx_next;
            msb_reg <= msb_next;
            bitCnt_reg <= bitCnt_next;
            ptr_reg <= ptr_next;
            byteIdx_reg <= byteIdx_next;
            rw_reg <= rw_next;
            ara_reg <= ara_next;
            rdLow_reg <= rdLow_next;
            ackSeen_reg <= ackSeen_next;
            sdaOe_reg <= sdaOe_next;
            startSingle <= start_next;
        end
    end

    assign sdaOe = sdaOe_reg;
    assign sdaOut = 1'b0; // Open drain, only ever pulls low
    assign configOut = cfg_reg;

    // Comparator, fault counter, ready pulse and pin drive
    logic [2:0] faultCnt_reg, faultCnt_next, need, cntInc;
    logic [`READY_CNT_W-1:0] rdyCnt_reg, rdyCnt_next;
    logic alert_next, above, below, isFault, active, alertOut_next, alertOe_next, queOff;

    always_comb begin
        above = $signed(convResult) > $signed(upper_reg); // RL16
        below = $signed(convResult) < $signed(lower_reg);
        isFault = cfg_reg.windowStyle ? (above | below) : above; // RL1 RL17
        queOff = cfg_reg.faultCountAndDisable == `QUE_OFF;
        unique case (cfg_reg.faultCountAndDisable)
            `QUE_ONE: need = `NEED_ONE; // RL6
            `QUE_TWO: need = `NEED_TWO; // RL6
            default: need = `NEED_FOUR; // RL6
        endcase
        cntInc = (faultCnt_reg >= need) ? need : faultCnt_reg + 3'h1;
        faultCnt_next = faultCnt_reg;
        alert_next = alertReg;
        conv_next = conv_reg;
        rdyCnt_next = (rdyCnt_reg != '0) ? rdyCnt_reg - `READY_CNT_W'(1) : rdyCnt_reg;
        if (linkClear) begin
            alert_next = 1'b0; // RL4
        end
        if (convDone) begin
            conv_next = convResult; // RL16
            if (rdyMode && !cfg_reg.singleShot) begin
                rdyCnt_next = `READY_CNT_W'(READY_PULSE); // RL13
            end
            if (isFault) begin
                faultCnt_next = cntInc;
                if (cntInc >= need) begin
                    alert_next = 1'b1; // RL6
                end
            end else begin
                faultCnt_next = 3'h0; // RL18
                if (!cfg_reg.alertLatchEnable && (cfg_reg.windowStyle || below)) begin
                    alert_next = 1'b0; // RL3 RL17
                end
            end
        end
        if (queOff || rdyMode) begin
            faultCnt_next = 3'h0; // RL7
            alert_next = 1'b0;
        end
        if (rdyMode) begin
            active = cfg_reg.singleShot ? ~convBusy : (rdyCnt_reg != '0); // RL12 RL13
        end else begin
            active = alertReg;
        end
        alertOut_next = cfg_reg.alertPinPolarity ? active : ~active; // RL2
        alertOe_next = ~queOff; // RL7
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            faultCnt_reg <= 3'h0;
            alertReg <= 1'b0;
            conv_reg <= `CONV_RESET;
            rdyCnt_reg <= '0;
            alertOut <= 1'b1;
            alertOe <= 1'b0;
        end else begin
            faultCnt_reg <= faultCnt_next;
            alertReg <= alert_next;
            conv_reg <= conv_next;
            rdyCnt_reg <= rdyCnt_next;
            alertOut <= alertOut_next;
            alertOe <= alertOe_next;
        end
    end

    // Checks on comparator and pin behaviour
    property p_disable;
        @(posedge clk) disable iff (sys_rst) queOff |=> !alertOe;
    endproperty
    a_disable: assert property (p_disable) else $error("alert pin driven while disabled"); // RL7

    property p_polarity;
        @(posedge clk) disable iff (sys_rst) (!queOff && !rdyMode)
            |=> alertOut == ($past(alertReg) ~^ $past(cfg_reg.alertPinPolarity));
    endproperty
    a_polarity: assert property (p_polarity) else $error("alert pin level wrong"); // RL2

    property p_countOne;
        @(posedge clk) disable iff (sys_rst) (convDone && isFault && !rdyMode
            && cfg_reg.faultCountAndDisable == `QUE_ONE) |=> alertReg;
    endproperty
    a_countOne: assert property (p_countOne) else $error("single fault did not alert"); // RL6

    property p_countFour;
        @(posedge clk) disable iff (sys_rst) (convDone && isFault && faultCnt_reg == 3'h0
            && !alertReg && cfg_reg.faultCountAndDisable == `QUE_FOUR) |=> !alertReg;
    endproperty
    a_countFour: assert property (p_countFour) else $error("alert before four faults"); // RL6

    property p_clearCount;
        @(posedge clk) disable iff (sys_rst) (convDone && !isFault) |=> faultCnt_reg == 3'h0;
    endproperty
    a_clearCount: assert property (p_clearCount) else $error("fault count not cleared"); // RL18

    property p_latch;
        @(posedge clk) disable iff (sys_rst) (alertReg && cfg_reg.alertLatchEnable
            && !linkClear && !queOff && !rdyMode) |=> alertReg;
    endproperty
    a_latch: assert property (p_latch) else $error("latched alert dropped"); // RL4

    property p_release;
        @(posedge clk) disable iff (sys_rst) (convDone && below && !above && !isFault
            && !cfg_reg.alertLatchEnable) |=> !alertReg;
    endproperty
    a_release: assert property (p_release) else $error("alert not released"); // RL3

    property p_traditional;
        @(posedge clk) disable iff (sys_rst) (convDone && !cfg_reg.windowStyle && below
            && !above) |=> faultCnt_reg == 3'h0;
    endproperty
    a_traditional: assert property (p_traditional) else $error("low result counted"); // RL1

    property p_readyPulse;
        @(posedge clk) disable iff (sys_rst) (convDone && rdyMode && !cfg_reg.singleShot)
            |=> rdyCnt_reg != '0;
    endproperty
    a_readyPulse: assert property (p_readyPulse) else $error("no ready pulse"); // RL13

    property p_readyIdle;
        @(posedge clk) disable iff (sys_rst) (rdyMode && cfg_reg.singleShot)
            |=> alertOut == ($past(convBusy) ^ $past(cfg_reg.alertPinPolarity));
    endproperty
    a_readyIdle: assert property (p_readyIdle) else $error("idle flag not on pin"); // RL12

    property p_result;
        @(posedge clk) disable iff (sys_rst) convDone |=> conv_reg == $past(convResult);
    endproperty
    a_result: assert property (p_result) else $error("result not held"); // RL16

endmodule : adc_threshold_alert_logic

/* verification/i2c_host_model.sv */
`timescale 1ns/10ps
module i2c_host_model (
    input wire logic clk, // Pacing clock
    input wire logic sdaWire, // Resolved data line
    output logic sclPin, // Serial clock
    output logic sdaPull // High pulls data low
);
    // Bus idle: clock stands high, data released
    initial begin
        sclPin = 1'b1;
        sdaPull = 1'b0;
    end
    // Pace by falling clock edges
    task automatic wt(input int n);
        repeat (n) @(negedge clk);
    endtask : wt
    // Start, also repeated start
    task automatic start();
        sdaPull = 1'b0;
        wt(8); // Let the device drop its acknowledge before the clock rises
        sclPin = 1'b1;
        wt(4);
        sdaPull = 1'b1;
        wt(4);
        sclPin = 1'b0;
    endtask : start
    // Stop, bus left released
    task automatic stop();
        sdaPull = 1'b1;
        wt(4);
        sclPin = 1'b1;
        wt(4);
        sdaPull = 1'b0;
        wt(4);
    endtask : stop
    // One bit of 16 clocks, data changed only while the clock is low
    task automatic bitx(input logic b, output logic r);
        wt(4);
        sdaPull = !b;
        wt(4);
        sclPin = 1'b1;
        wt(4);
        r = sdaWire;
        wt(4);
        sclPin = 1'b0;
    endtask : bitx
    // Eight bits, then the acknowledge bit (m high releases it)
    task automatic xbyte(input logic [7:0] d, input logic m, output logic [7:0] q,
        output logic a);
        for (int i = 7; i >= 0; i--) begin
            bitx(d[i], q[i]);
        end
        bitx(m, a);
    endtask : xbyte
endmodule : i2c_host_model

/* verification/test_adc_threshold_alert_logic.sv */
`timescale 1ns/10ps
module test_adc_threshold_alert_logic;
    localparam int RP = 4;
    logic clk, sys_rst, sdaOut, sdaOe, convDone, convBusy, startSingle, alertOut, alertOe;
    logic sclPin, sdaPull, sdaWire, a;
    logic [6:0] devAddr;
    logic [7:0] q;
    logic [15:0] convResult, lo, hi;
    adc_alert_pkg::cfg_t configOut;
    int fails, num_checks, n, starts;
    // Pull-up unless a party drives low
    assign sdaWire = !(sdaOe || sdaPull);
    adc_threshold_alert_logic #(.READY_PULSE(RP)) u_dut (.clk(clk), .sys_rst(sys_rst),
        .sclIn(sclPin), .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOe(sdaOe), .devAddr(devAddr),
        .convDone(convDone), .convResult(convResult), .convBusy(convBusy),
        .configOut(configOut), .startSingle(startSingle), .alertOut(alertOut),
        .alertOe(alertOe));
    i2c_host_model u_host (.clk(clk), .sdaWire(sdaWire), .sclPin(sclPin), .sdaPull(sdaPull));
    // Compare and count
    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : test_done
    // Configuration word: style, polarity, latch, fault code, single-shot
    function automatic logic [15:0] cfgw(input logic st, pl, lt, input logic [1:0] c,
        input logic ss);
        return {7'h00, ss, 3'h4, st, pl, lt, c};
    endfunction : cfgw
    // Pin level for an alert state under a polarity
    function automatic logic [15:0] lvl(input logic act, input logic pl);
        return {15'h0000, act ~^ pl};
    endfunction : lvl
    function automatic logic [15:0] above();
        return hi + 16'h0001 + 16'($urandom % 64);
    endfunction : above
    function automatic logic [15:0] below();
        return lo - 16'h0001 - 16'($urandom % 64);
    endfunction : below
    // Pointer, then one 16-bit word
    task automatic wreg(input logic [1:0] p, input logic [15:0] v);
        u_host.start();
        u_host.xbyte({devAddr, 1'b0}, 1'b1, q, a);
        u_host.xbyte({6'h00, p}, 1'b1, q, a);
        u_host.xbyte(v[15:8], 1'b1, q, a);
        u_host.xbyte(v[7:0], 1'b1, q, a);
        u_host.stop();
    endtask : wreg
    // Pointer, repeated start, word read back and compared
    task automatic rchk(input string nm, input logic [1:0] p, input logic [15:0] exp);
        logic [15:0] v;
        u_host.start();
        u_host.xbyte({devAddr, 1'b0}, 1'b1, q, a);
        u_host.xbyte({6'h00, p}, 1'b1, q, a);
        u_host.start();
        u_host.xbyte({devAddr, 1'b1}, 1'b1, q, a);
        u_host.xbyte(8'hFF, 1'b0, v[15:8], a);
        u_host.xbyte(8'hFF, 1'b1, v[7:0], a);
        u_host.stop();
        check(nm, v, exp);
    endtask : rchk
    // One conversion result, then let the pin settle
    task automatic conv(input logic [15:0] v);
        @(negedge clk);
        convDone = 1'b1;
        convResult = v;
        @(negedge clk);
        convDone = 1'b0;
        repeat (3) @(negedge clk);
    endtask : conv
    task automatic pin(input logic act, input logic pl);
        check("alertOe", {15'h0000, alertOe}, 16'h0001);
        check("alertOut", {15'h0000, alertOut}, lvl(act, pl));
    endtask : pin
    // Clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Count single-shot start pulses
    always @(negedge clk) starts += int'(startSingle === 1'b1);
    // Hang guard
    initial begin
        #800000;
        fails++;
        test_done();
    end
    // Main sequence
    initial begin
        sys_rst = 1'b1;
        convDone = 1'b0;
        convBusy = 1'b0;
        convResult = 16'h0000;
        void'($urandom(97));
        devAddr = 7'h48 | 7'($urandom % 4);
        repeat (12) @(negedge clk);
        sys_rst = 1'b0;
        repeat (6) @(negedge clk);
        check("alertOe", {15'h0000, alertOe}, 16'h0000);
        rchk("conv", 2'h0, 16'h0000);
        rchk("lower", 2'h2, 16'h8000);
        rchk("upper", 2'h3, 16'h7FFF);
        rchk("config", 2'h1, 16'h8583);
        lo = 16'h0100 + 16'($urandom % 4096);
        hi = lo + 16'h1000 + 16'($urandom % 256);
        wreg(2'h2, lo);
        wreg(2'h3, hi);
        rchk("upper", 2'h3, hi);
        conv(above());
        check("alertOe", {15'h0000, alertOe}, 16'h0000);
        // Each fault count, an interrupted run, then hold and release
        for (int c = 0; c < 3; c++) begin
            wreg(2'h1, cfgw(1'b0, c[0], 1'b0, 2'(c), 1'b1));
            repeat ((1 << c) - 1) conv(above());
            conv(hi);
            repeat ((1 << c) - 1) conv(above());
            pin(1'b0, c[0]);
            conv(above());
            pin(1'b1, c[0]);
            check("polarity", {15'h0000, alertOut}, {15'h0000, c[0]});
            conv(lo);
            pin(1'b1, c[0]);
            conv(below());
            pin(1'b0, c[0]);
        end
        // Latched alert: data read clears, then alert response clears
        wreg(2'h1, cfgw(1'b0, 1'b0, 1'b1, 2'h0, 1'b1));
        conv(above());
        conv(below());
        pin(1'b1, 1'b0);
        rchk("conv", 2'h0, convResult);
        pin(1'b0, 1'b0);
        conv(above());
        u_host.start();
        u_host.xbyte(8'h19, 1'b1, q, a);
        u_host.xbyte(8'hFF, 1'b1, q, a);
        u_host.stop();
        check("respAddr", {8'h00, q}, {8'h00, devAddr, 1'b0});
        pin(1'b0, 1'b0);
        // Window style
        wreg(2'h1, cfgw(1'b1, 1'b1, 1'b0, 2'h0, 1'b1));
        conv(below());
        pin(1'b1, 1'b1);
        conv(lo + 16'h0800);
        pin(1'b0, 1'b1);
        // Ready signalling, continuous then single-shot
        wreg(2'h2, 16'h0000);
        wreg(2'h3, 16'h8000);
        wreg(2'h1, cfgw(1'b0, 1'b0, 1'b0, 2'h0, 1'b0));
        @(negedge clk);
        convDone = 1'b1;
        @(negedge clk);
        convDone = 1'b0;
        n = 0;
        repeat (12) begin
            @(negedge clk);
            n += int'(alertOut === 1'b0);
        end
        check("readyLen", 16'(n), 16'(RP));
        wreg(2'h1, cfgw(1'b0, 1'b0, 1'b0, 2'h0, 1'b1));
        convBusy = 1'b1;
        repeat (3) @(negedge clk);
        pin(1'b0, 1'b0);
        rchk("config", 2'h1, cfgw(1'b0, 1'b0, 1'b0, 2'h0, 1'b1));
        convBusy = 1'b0;
        repeat (3) @(negedge clk);
        pin(1'b1, 1'b0);
        check("configOut", configOut, cfgw(1'b0, 1'b0, 1'b0, 2'h0, 1'b1));
        check("sdaOut", {15'h0000, sdaOut}, 16'h0000);
        wreg(2'h1, 16'h8000 | cfgw(1'b0, 1'b0, 1'b0, 2'h0, 1'b1));
        check("startSingle", 16'(starts), 16'h0001);
        test_done();
    end
endmodule : test_adc_threshold_alert_logic
